// File: irq_params.svh
// constants for the interrupt mask and vector registers
//
// Notes on behaviour
// [R1] general mask E0h: b0 monitor, b1-4 analog, b5 GPIO, b7 reserved.
// [R2] general mask bit 6 enables the sleep timer interrupt.
// [R3] block mask at E1h: each bit enables one digital block interrupt.
// [R4] block mask bits 0-3 are basic blocks, bits 4-7 are comm blocks.
// [R5] a vector read gives the highest-priority pending vector.
// [R6] any write to the vector register clears all pending flags.
// [R7] vector register sits at E2h as one 8-bit location.
// [R8] reset clears both masks and the global interrupt enable.
// [R9] each source latches a flag until serviced, reset or vector write.
// [R10] a request needs pending, its mask bit and the global enable.
// [R11] priority 1 (monitor) to 15 (sleep), lowest first; vector 4*priority.
// [R12] nothing pending reads 00h; reserved mask bit 7 affects nothing.
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

`define ADDR_GENERAL_MASK   8'hE0
`define ADDR_BLOCK_MASK     8'hE1
`define ADDR_IRQ_VECTOR     8'hE2
`define MASK_RESET          8'h00
`define VECTOR_NONE         8'h00
`define RDATA_RESET         8'h00
`define UNMAPPED_READ       8'h00
`define GIE_RESET           1'b0
`define VECTOR_BASE         8'h04
`define VECTOR_STEP         8'h04
`define NUM_SOURCES         15
`define GM_MONITOR_BIT      0
`define GM_ANALOG_LO_BIT    1
`define GM_ANALOG_HI_BIT    4
`define GM_GPIO_BIT         5
`define GM_SLEEP_BIT        6
`define SRC_MONITOR         0
`define SRC_BLOCK_LO        1
`define SRC_BLOCK_HI        8
`define SRC_ANALOG_LO       9
`define SRC_ANALOG_HI       12
`define SRC_GPIO            13
`define SRC_SLEEP           14

`endif

// File: irq_pkg.sv
// types shared by the interrupt mask and vector logic
`default_nettype none
package irq_pkg;
    typedef struct packed {
        logic       wr;    // one-cycle write strobe
        logic       rd;    // one-cycle read strobe
        logic [7:0] addr;  // bank 0 address
        logic [7:0] wdata; // write data
    } reg_req_type;
endpackage
`default_nettype wire

// File: irq_prio_enc.sv
// lowest-index-first priority encoder
`default_nettype none
module irq_prio_enc #(
    parameter int N = 15
) (
    input  wire logic [N-1:0]         req,   // requests
    output logic                      found, // any request
    output logic [$clog2(N)-1:0]      idx    // lowest set index
);
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = i[$clog2(N)-1:0];
            end
        end
    end
endmodule // irq_prio_enc
`default_nettype wire

// File: irq_mask_vector.sv
// interrupt mask registers, pending flags and vector register
`include "irq_params.svh"
`default_nettype none
module irq_mask_vector
    import irq_pkg::*;
#(
    parameter int NSRC = `NUM_SOURCES
) (
    input  wire logic                  clk_sys,    // system clock
    input  wire logic                  rst_b,      // async reset, low
    input  wire logic                  clkEn,      // freezes state when low
    input  wire reg_req_type           regReq,     // cpu register access
    output logic [7:0]                 regRdData,  // read data, next cycle
    input  wire logic [NSRC-1:0]       srcEvent,   // source pulses by priority
    input  wire logic                  gieWrEn,    // cpu updates global enable
    input  wire logic                  gieWrData,  // new global enable value
    input  wire logic                  irqAck,     // cpu services current irq
    output logic                       globalIrqEnable, // global enable flag
    output logic                       irqReq,     // request to the cpu
    output logic [7:0]                 irqVector,  // vector of current irq
    output logic [NSRC-1:0]            pendingOut  // pending flags
);
    localparam int IW = $clog2(NSRC);

    // ------------------------------------------------------------
    // state and decode signals
    // ------------------------------------------------------------
    logic [7:0]      generalMask_ff;
    logic [7:0]      nxt_generalMask;
    logic [7:0]      blockMask_ff;
    logic [7:0]      nxt_blockMask;
    logic            gie_ff;
    logic            nxt_gie;
    wire  logic [NSRC-1:0] pendingFlags;
    logic [7:0]      rdData_ff;
    logic [7:0]      nxt_rdData;
    logic [NSRC-1:0] enable;
    logic [NSRC-1:0] active;
    logic            anyActive;
    logic [IW-1:0]   activeIdx;
    logic [7:0]      vector;
    logic            wrGeneral;
    logic            wrBlock;
    logic            wrVector;
    logic            ackTaken;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign wrGeneral = regReq.wr
                    && (regReq.addr == `ADDR_GENERAL_MASK); // [R1]
    assign wrBlock   = regReq.wr
                    && (regReq.addr == `ADDR_BLOCK_MASK); // [R3]
    assign wrVector  = regReq.wr
                    && (regReq.addr == `ADDR_IRQ_VECTOR); // [R7]
    // only a request the cpu can see may be serviced
    assign ackTaken  = irqAck && irqReq; // [R9]

    // ------------------------------------------------------------
    // mask registers
    // ------------------------------------------------------------
    always_comb begin
        nxt_generalMask = generalMask_ff;
        nxt_blockMask   = blockMask_ff;
        if (wrGeneral) begin
            nxt_generalMask = regReq.wdata; // [R1] [R2]
        end
        if (wrBlock) begin
            nxt_blockMask = regReq.wdata; // [R3]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            generalMask_ff <= `MASK_RESET; // [R8]
            blockMask_ff   <= `MASK_RESET; // [R8]
        end else if (clkEn) begin
            generalMask_ff <= nxt_generalMask;
            blockMask_ff   <= nxt_blockMask;
        end
    end

    // ------------------------------------------------------------
    // global interrupt enable
    // ------------------------------------------------------------
    always_comb begin
        nxt_gie = gie_ff;
        if (gieWrEn) begin
            nxt_gie = gieWrData; // [R10]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gie_ff <= `GIE_RESET; // [R8]
        end else if (clkEn) begin
            gie_ff <= nxt_gie;
        end
    end

    // ------------------------------------------------------------
    // source enables and prioritisation
    // ------------------------------------------------------------
    always_comb begin
        enable = '0;
        enable[`SRC_MONITOR] = generalMask_ff[`GM_MONITOR_BIT]; // [R1]
        enable[`SRC_BLOCK_HI:`SRC_BLOCK_LO] = blockMask_ff; // [R3] [R4]
        enable[`SRC_ANALOG_HI:`SRC_ANALOG_LO] =
            generalMask_ff[`GM_ANALOG_HI_BIT:`GM_ANALOG_LO_BIT]; // [R1]
        enable[`SRC_GPIO]  = generalMask_ff[`GM_GPIO_BIT]; // [R1]
        enable[`SRC_SLEEP] = generalMask_ff[`GM_SLEEP_BIT]; // [R2]
        // bit 7 of the general mask feeds nothing
    end // [R12]

    // masked flags stay latched but never reach the encoder
    assign active = pendingFlags & enable;

    irq_prio_enc #(
        .N(NSRC)
    ) irq_prio_enc_i (
        .req   (active),
        .found (anyActive),
        .idx   (activeIdx)
    ); // [R11]

    always_comb begin
        if (anyActive) begin
            vector = `VECTOR_BASE + 8'(activeIdx) * `VECTOR_STEP; // [R11]
        end else begin
            vector = `VECTOR_NONE; // [R12]
        end
    end

    assign irqReq = anyActive & gie_ff; // [R10]

    // ------------------------------------------------------------
    // pending flags, one per source
    // ------------------------------------------------------------
    generate
        for (genvar s = 0; s < NSRC; s++) begin : g_flag
            logic flag_ff;
            logic nxt_flag;

            always_comb begin
                nxt_flag = flag_ff;
                if (wrVector) begin
                    nxt_flag = 1'b0; // [R6]
                end else if (ackTaken && (activeIdx == IW'(s))) begin
                    nxt_flag = 1'b0; // [R9]
                end
                // a new event beats a clear in the same cycle
                if (srcEvent[s]) begin
                    nxt_flag = 1'b1; // [R9]
                end
            end

            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    flag_ff <= 1'b0; // [R9]
                end else if (clkEn) begin
                    flag_ff <= nxt_flag;
                end
            end

            assign pendingFlags[s] = flag_ff;
        end
    endgenerate

    // ------------------------------------------------------------
    // register read data
    // ------------------------------------------------------------
    always_comb begin
        nxt_rdData = rdData_ff;
        if (regReq.rd) begin
            unique case (regReq.addr)
                `ADDR_GENERAL_MASK: nxt_rdData = generalMask_ff;
                `ADDR_BLOCK_MASK:   nxt_rdData = blockMask_ff;
                `ADDR_IRQ_VECTOR:   nxt_rdData = vector; // [R5]
                default:            nxt_rdData = `UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdData_ff <= `RDATA_RESET;
        end else if (clkEn) begin
            rdData_ff <= nxt_rdData;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign irqVector       = vector;
    assign globalIrqEnable = gie_ff;
    assign pendingOut      = pendingFlags;
    assign regRdData       = rdData_ff;
endmodule // irq_mask_vector
`default_nettype wire

// File: irq_mask_vector_props.sv
// assertions on the ports of the interrupt mask and vector block
`default_nettype none
module irq_mask_vector_props
    import irq_pkg::*;
#(
    parameter int NSRC = 15
) (
    input wire logic            clk_sys,         // clock
    input wire logic            rst_b,           // reset, low
    input wire logic            clkEn,           // clock enable
    input wire reg_req_type     regReq,          // access
    input wire logic [7:0]      regRdData,       // read data
    input wire logic [NSRC-1:0] srcEvent,        // events
    input wire logic            gieWrEn,         // gie load
    input wire logic            gieWrData,       // gie value
    input wire logic            irqAck,          // service
    input wire logic            globalIrqEnable, // gie
    input wire logic            irqReq,          // request
    input wire logic [7:0]      irqVector,       // vector
    input wire logic [NSRC-1:0] pendingOut       // flags
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_vec_clear: assert property (clkEn && regReq.wr &&
        regReq.addr == 8'hE2 && !srcEvent |=> !pendingOut) else $error("kept");
    a_flag_set: assert property (clkEn |=>
        (pendingOut & $past(srcEvent)) == $past(srcEvent)) else $error("lost");
    a_flag_hold: assert property (clkEn && !irqAck && !regReq.wr |=>
        (pendingOut & $past(pendingOut)) == $past(pendingOut))
        else $error("drop");
    a_req_gie: assert property (irqReq |-> globalIrqEnable)
        else $error("gie");
    a_gie_load: assert property (clkEn && gieWrEn |=>
        globalIrqEnable == $past(gieWrData)) else $error("gie load");
    a_vec_form: assert property (irqVector != 8'h00 |->
        irqVector[1:0] == 2'h0 && pendingOut[(irqVector >> 2) - 1])
        else $error("vector form");
    a_none_zero: assert property (!pendingOut |->
        irqVector == 8'h00 && !irqReq) else $error("idle vector");
    a_vec_read: assert property (clkEn && regReq.rd &&
        regReq.addr == 8'hE2 |=> regRdData == $past(irqVector))
        else $error("read vector");
endmodule // irq_mask_vector_props
bind irq_mask_vector irq_mask_vector_props #(.NSRC(NSRC)) props_i (.clk_sys,
    .rst_b, .clkEn, .regReq, .regRdData, .srcEvent, .gieWrEn, .gieWrData,
    .irqAck, .globalIrqEnable, .irqReq, .irqVector, .pendingOut);
`default_nettype wire

// File: irq_cpu_model.sv
// cpu-side model issuing bank 0 register accesses
`default_nettype none
module irq_cpu_model
    import irq_pkg::*;
(
    input  wire logic [7:0] regRdData, // read data
    input  wire logic       clk_sys,   // clock
    output var reg_req_type regReq     // request
);
    timeunit 1ns;
    timeprecision 100ps;
    initial regReq = '0;
    task automatic acc(input logic [1:0] k, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_sys) regReq <= {k, a, d};
        @(negedge clk_sys) q = regRdData;
        regReq <= '0;
    endtask
endmodule // irq_cpu_model
`default_nettype wire

// File: irq_mask_vector_tb_top.sv
// self-checking bench for the interrupt mask and vector block
`default_nettype none
module irq_mask_vector_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import irq_pkg::*;
    logic        clk_sys   = 1'b0;
    logic        rst_b     = 1'b0;
    logic        clkEn     = 1'b1;
    logic        gieWrEn   = 1'b0;
    logic        gieWrData = 1'b0;
    logic        irqAck    = 1'b0;
    logic        irqReq;
    logic        gie;
    logic [14:0] srcEvent  = '0;
    logic [14:0] pendingOut;
    logic [7:0]  regRdData;
    logic [7:0]  irqVector;
    logic [7:0]  d;
    logic [7:0]  g;
    logic [7:0]  b;
    reg_req_type regReq;
    int          err_count = 0;
    int          checked   = 0;
    always #12.5 clk_sys = ~clk_sys;
    irq_cpu_model irq_cpu_model_i (.clk_sys, .regRdData, .regReq);
    irq_mask_vector irq_mask_vector_i (.clk_sys, .rst_b, .clkEn, .regReq,
        .regRdData, .srcEvent, .gieWrEn, .gieWrData, .irqAck,
        .globalIrqEnable(gie), .irqReq, .irqVector, .pendingOut);
    task automatic set_gie(input logic v);
        @(negedge clk_sys);
        gieWrEn   <= 1'b1;
        gieWrData <= v;
        @(negedge clk_sys);
        gieWrEn   <= 1'b0;
    endtask
    task automatic fire(input logic [14:0] e);
        @(negedge clk_sys);
        srcEvent <= e;
        @(negedge clk_sys);
        srcEvent <= '0;
    endtask
    task automatic chk(string n, logic [14:0] e, g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("gie reset", 15'h0000, {14'h0000, gie});
        chk("pend reset", 15'h0000, pendingOut);
        rst_b <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            irq_cpu_model_i.acc(2'h1, 8'hE0 + 8'(a), 8'h00, d);
            chk("reset reg", 15'h0000, {7'h00, d});
        end
        irq_cpu_model_i.acc(2'h2, 8'hE0, 8'hA5, d);
        irq_cpu_model_i.acc(2'h1, 8'hE0, 8'h00, d);
        chk("gen mask", 15'h00A5, {7'h00, d});
        irq_cpu_model_i.acc(2'h2, 8'hE1, 8'h5A, d);
        irq_cpu_model_i.acc(2'h1, 8'hE1, 8'h00, d);
        chk("blk mask", 15'h005A, {7'h00, d});
        set_gie(1'b1);
        chk("gie on", 15'h0001, {14'h0000, gie});
        for (int i = 0; i < 15; i++) begin
            b = (i > 0 && i < 9) ? 8'(8'h01 << (i - 1)) : 8'h00;
            g = (i == 0) ? 8'h01 : (i > 8) ? 8'(8'h01 << (i - 8)) : 8'h00;
            irq_cpu_model_i.acc(2'h2, 8'hE0, g, d);
            irq_cpu_model_i.acc(2'h2, 8'hE1, b, d);
            fire(15'h7FFF);
            irq_cpu_model_i.acc(2'h1, 8'hE2, 8'h00, d);
            chk("vector", 15'(4 * (i + 1)), {7'h00, d});
            chk("request", 15'h0001, {14'h0000, irqReq});
            chk("pending", 15'h7FFF, pendingOut);
            irq_cpu_model_i.acc(2'h2, 8'hE2, 8'(i), d);
            chk("cleared", 15'h0000, pendingOut);
        end
        irq_cpu_model_i.acc(2'h2, 8'hE0, 8'h80, d);
        fire(15'h7FFF);
        chk("reserved", 15'h0000, {7'h00, irqVector});
        chk("masked req", 15'h0000, {14'h0000, irqReq});
        irq_cpu_model_i.acc(2'h2, 8'hE1, 8'h02, d);
        irq_cpu_model_i.acc(2'h2, 8'hE0, 8'h81, d);
        irq_cpu_model_i.acc(2'h1, 8'hE2, 8'h00, d);
        chk("top vector", 15'h0004, {7'h00, d});
        @(negedge clk_sys);
        irqAck <= 1'b1;
        @(negedge clk_sys);
        irqAck <= 1'b0;
        chk("acked", 15'h7FFE, pendingOut);
        irq_cpu_model_i.acc(2'h1, 8'hE2, 8'h00, d);
        chk("next vector", 15'h000C, {7'h00, d});
        @(negedge clk_sys);
        clkEn <= 1'b0;
        irq_cpu_model_i.acc(2'h2, 8'hE2, 8'h00, d);
        chk("frozen", 15'h7FFE, pendingOut);
        clkEn <= 1'b1;
        chk("req on", 15'h0001, {14'h0000, irqReq});
        set_gie(1'b0);
        chk("gie off", 15'h0000, {14'h0000, irqReq});
        chk("gie flag", 15'h0000, {14'h0000, gie});
        irq_cpu_model_i.acc(2'h2, 8'hE2, 8'h33, d);
        chk("vec clear", 15'h0000, pendingOut);
        irq_cpu_model_i.acc(2'h1, 8'hE2, 8'h00, d);
        chk("idle vector", 15'h0000, {7'h00, d});
        stop_test;
    end
    initial begin
        #50000;
        err_count++;
        stop_test;
    end
endmodule // irq_mask_vector_tb_top
`default_nettype wire
